// ==== design/iowd_top.v ====
`include "iowd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module iowd_top #(
  parameter NU    = `IOWD_NUM_USER,
  parameter DIV_W = `IOWD_DIV_W,
  parameter WD_W  = `IOWD_WD_W
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             srst_i,
  // user signals
  input  wire [NU-1:0]    usr_dir_i,
  input  wire [NU-1:0]    usr_out_i,
  input  wire [NU-1:0]    usr_ie_i,
  input  wire [NU-1:0]    usr_clr_i,
  input  wire [NU-1:0]    usr_pin_i,
  output reg  [NU-1:0]    usr_pin_o,
  output reg  [NU-1:0]    usr_pin_oe_n_o,
  output reg  [NU-1:0]    usr_in_o,
  output reg  [NU-1:0]    usr_flag_o,
  output reg              usr_irq_o,
  // serial control
  input  wire [DIV_W-1:0] baud_div_i,
  input  wire [7:0]       tx_data_i,
  input  wire             tx_valid_i,
  output wire             tx_ready_o,
  output reg  [7:0]       rx_data_o,
  output reg              rx_valid_o,
  input  wire             rx_ready_i,
  output reg              rx_err_o,
  // line
  input  wire             line_rx_i,
  output reg              line_tx_o,
  output reg              line_de_o,
  // watchdog
  input  wire             wd_en_i,
  input  wire             wd_kick_i,
  input  wire             wd_host_up_i,
  input  wire [WD_W-1:0]  wd_warn_iv_i,
  input  wire [WD_W-1:0]  wd_tout_iv_i,
  input  wire [WD_W-1:0]  wd_rbt_iv_i,
  input  wire             wd_warn_clr_i,
  output reg              wd_warn_irq_o,
  output reg              wd_reboot_o,
  output reg              wd_in_reboot_o
);
  // user bank
  reg [NU-1:0] prev_r;
  genvar g;
  generate
    for (g = 0; g < NU; g = g + 1)
    begin : g_usr
      always @(posedge clk_i)
      begin
        if (srst_i)
        begin
          usr_pin_o[g]      <= 1'b0;
          usr_pin_oe_n_o[g] <= 1'b1;
          usr_in_o[g]       <= usr_pin_i[g]; // track pin: no false edge at release
          prev_r[g]         <= usr_pin_i[g];
          usr_flag_o[g]     <= 1'b0;
        end
        else
        begin
          usr_pin_o[g]      <= usr_out_i[g];
          usr_pin_oe_n_o[g] <= ~usr_dir_i[g];
          usr_in_o[g]       <= usr_pin_i[g];
          prev_r[g]         <= usr_in_o[g];
          // set wins over clear
          if (!usr_dir_i[g] && usr_ie_i[g] && (usr_in_o[g] != prev_r[g]))
            usr_flag_o[g] <= 1'b1;
          else if (usr_clr_i[g])
            usr_flag_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clk_i)
  begin
    if (srst_i)
      usr_irq_o <= 1'b0;
    else
      usr_irq_o <= |usr_flag_o;
  end

  // serial: tx buffered, half duplex
  wire [7:0] tb_data;
  wire       tb_valid;
  reg        tb_pop;
  iowd_buf2 #(
    .W (8)
  ) u_txbuf (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .in_data_i   (tx_data_i),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (tb_data),
    .out_valid_o (tb_valid),
    .out_ready_i (tb_pop)
  );

  localparam S_IDLE = 2'd0;
  localparam S_TX   = 2'd1;
  localparam S_RX   = 2'd2;
  reg [1:0]       st_r;
  reg [DIV_W-1:0] bcnt_r;
  reg [3:0]       bit_r;
  reg [9:0]       sh_r;
  reg             rx1_r;
  reg             rx2_r;
  wire [DIV_W-1:0] div_m1 = (baud_div_i == {DIV_W{1'b0}}) ? {DIV_W{1'b0}}
                                                           : baud_div_i - 1'b1;
  wire            tick = (bcnt_r == {DIV_W{1'b0}});

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st_r       <= S_IDLE;
      bcnt_r     <= {DIV_W{1'b0}};
      bit_r      <= 4'd0;
      sh_r       <= 10'h3ff;
      rx1_r      <= 1'b1;
      rx2_r      <= 1'b1;
      line_tx_o  <= 1'b1;
      line_de_o  <= 1'b0;
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_err_o   <= 1'b0;
      tb_pop     <= 1'b0;
    end
    else
    begin
      rx1_r  <= line_rx_i;
      rx2_r  <= rx1_r;
      tb_pop <= 1'b0;
      if (rx_valid_o && rx_ready_i)
        rx_valid_o <= 1'b0;
      bcnt_r <= tick ? div_m1 : bcnt_r - 1'b1;
      case (st_r)
        S_IDLE:
        begin
          line_de_o <= 1'b0;
          line_tx_o <= 1'b1;
          if (!rx2_r)
          begin
            st_r   <= S_RX;
            bcnt_r <= {1'b0, div_m1[DIV_W-1:1]};
            bit_r  <= 4'd0;
          end
          else if (tb_valid && !tb_pop)
          begin
            st_r      <= S_TX;
            sh_r      <= {1'b1, tb_data, 1'b0};
            tb_pop    <= 1'b1;
            bit_r     <= 4'd0;
            bcnt_r    <= div_m1;
            line_de_o <= 1'b1;
            line_tx_o <= 1'b0;
          end
        end
        S_TX:
        begin
          if (tick)
          begin
            if (bit_r == 4'd9)
            begin
              st_r      <= S_IDLE;
              line_de_o <= 1'b0;
            end
            else
            begin
              bit_r     <= bit_r + 4'd1;
              line_tx_o <= sh_r[bit_r + 4'd1];
            end
          end
        end
        S_RX:
        begin
          if (tick)
          begin
            bcnt_r <= div_m1;
            if (bit_r == 4'd0 && rx2_r)
              st_r <= S_IDLE;
            else if (bit_r == 4'd9)
            begin
              st_r <= S_IDLE;
              if (!rx_valid_o || rx_ready_i)
              begin
                rx_data_o  <= sh_r[8:1];
                rx_valid_o <= 1'b1;
              end
              rx_err_o <= ~rx2_r;
            end
            else
            begin
              bit_r       <= bit_r + 4'd1;
              sh_r[bit_r] <= rx2_r;
            end
          end
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // watchdog
  reg [WD_W-1:0] warn_r;
  reg [WD_W-1:0] tout_r;
  reg [WD_W-1:0] rbt_r;
  reg [15:0]     pulse_r;
  reg            warned_r;

  always @(posedge clk_i)
  begin
    if (srst_i || !wd_en_i)
    begin
      warn_r         <= `IOWD_WARN_DEF;
      tout_r         <= `IOWD_TOUT_DEF;
      rbt_r          <= `IOWD_RBT_DEF;
      pulse_r        <= 16'h0000;
      warned_r       <= 1'b0;
      wd_warn_irq_o  <= 1'b0;
      wd_reboot_o    <= 1'b0;
      wd_in_reboot_o <= 1'b0;
    end
    else
    begin
      wd_reboot_o <= (pulse_r != 16'h0000);
      if (pulse_r != 16'h0000)
        pulse_r <= pulse_r - 16'h0001;
      if (wd_in_reboot_o)
      begin
        if (wd_host_up_i)
        begin
          wd_in_reboot_o <= 1'b0;
          warn_r         <= wd_warn_iv_i;
          tout_r         <= wd_tout_iv_i;
          warned_r       <= 1'b0;
        end
        else if (rbt_r == {WD_W{1'b0}})
        begin
          pulse_r <= `IOWD_RBT_PULSE;
          rbt_r   <= wd_rbt_iv_i;
        end
        else
          rbt_r <= rbt_r - 1'b1;
      end
      else if (wd_kick_i)
      begin
        warn_r   <= wd_warn_iv_i;
        tout_r   <= wd_tout_iv_i;
        warned_r <= 1'b0;
      end
      else
      begin
        if (warn_r != {WD_W{1'b0}})
          warn_r <= warn_r - 1'b1;
        else if (!warned_r)
        begin
          warned_r      <= 1'b1;
          wd_warn_irq_o <= 1'b1;
        end
        if (tout_r == {WD_W{1'b0}})
        begin
          pulse_r        <= `IOWD_RBT_PULSE;
          wd_in_reboot_o <= 1'b1;
          rbt_r          <= wd_rbt_iv_i;
        end
        else
          tout_r <= tout_r - 1'b1;
      end
      if (wd_warn_clr_i && !(warn_r == {WD_W{1'b0}} && !warned_r))
        wd_warn_irq_o <= 1'b0;
    end
  end
endmodule // iowd_top
`default_nettype wire

// ==== common/iowd_defines.vh ====
`ifndef IOWD_DEFINES_VH
`define IOWD_DEFINES_VH

// user signal bank
`define IOWD_NUM_USER      16
// serial defaults
`define IOWD_CLK_HZ        40000000
`define IOWD_BAUD_MAX      9600
`define IOWD_BAUD_DIV_DEF  16'h0104
`define IOWD_DIV_W         16
// watchdog interval defaults, in clock cycles
`define IOWD_WD_W          32
`define IOWD_WARN_DEF      32'h0100_0000
`define IOWD_TOUT_DEF      32'h0200_0000
`define IOWD_RBT_DEF       32'h0400_0000
// reboot pulse length, cycles
`define IOWD_RBT_PULSE     16'h0010

`endif

// ==== design/iowd_buf2.v ====
`timescale 1ns/10ps
`default_nettype none
// two-entry skid buffer
module iowd_buf2 #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         srst_i,
  // fill side
  input  wire [W-1:0] in_data_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  // drain side
  output wire [W-1:0] out_data_o,
  output wire         out_valid_o,
  input  wire         out_ready_i
);
  reg [W-1:0] mem_r [0:1];
  reg         wp_r;
  reg         rp_r;
  reg [1:0]   cnt_r;
  reg [1:0]   cnt_nxt;
  reg         rdy_r;
  reg         vld_r;
  wire        push = in_valid_i && rdy_r;
  wire        pop  = out_ready_i && vld_r;

  // handshake flags kept in flops so the ports come straight from registers
  assign in_ready_o  = rdy_r;
  assign out_valid_o = vld_r;
  assign out_data_o  = mem_r[rp_r];

  always @*
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 2'd1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 2'd1;
  end

  always @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'd0;
      rdy_r <= 1'b1;
      vld_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        mem_r[wp_r] <= in_data_i;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != 2'd2);
      vld_r <= (cnt_nxt != 2'd0);
    end
  end
endmodule // iowd_buf2
`default_nettype wire

// ==== testbench/iowd_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module iowd_sva (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        srst_i,
  // user signals
  input wire logic [15:0] usr_dir_i,
  input wire logic [15:0] usr_out_i,
  input wire logic [15:0] usr_clr_i,
  input wire logic [15:0] usr_pin_o,
  input wire logic [15:0] usr_pin_oe_n_o,
  input wire logic [15:0] usr_flag_o,
  // line
  input wire logic        line_tx_o,
  input wire logic        line_de_o,
  // watchdog
  input wire logic        wd_en_i,
  input wire logic        wd_kick_i,
  input wire logic [31:0] wd_warn_iv_i,
  input wire logic        wd_warn_clr_i,
  input wire logic        wd_warn_irq_o,
  input wire logic        wd_reboot_o,
  input wire logic        wd_in_reboot_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // cycles since the last kick or enable
  logic [31:0] since_r;
  always @(posedge clk_i)
    if (srst_i || !wd_en_i || wd_kick_i)
      since_r <= 32'h0000_0000;
    else
      since_r <= since_r + 32'h0000_0001;
  sequence s_pulse;
    wd_reboot_o [*8] ##1 wd_reboot_o [*8] ##1 !wd_reboot_o;
  endsequence
  a_pin_follow: assert property (
    1 |=> usr_pin_o == $past(usr_out_i) && usr_pin_oe_n_o == ~$past(usr_dir_i))
    else $error("pin drive");
  a_flag_sticky: assert property (
    !$past(srst_i) |-> (~usr_flag_o & $past(usr_flag_o) & ~$past(usr_clr_i)) == 16'h0000)
    else $error("flag lost");
  a_line_idle: assert property (!line_de_o |-> line_tx_o)
    else $error("idle line");
  a_start_low: assert property ($rose(line_de_o) |-> !line_tx_o)
    else $error("start bit");
  a_wd_off: assert property (
    !wd_en_i |=> !wd_warn_irq_o && !wd_reboot_o && !wd_in_reboot_o)
    else $error("disabled watchdog");
  a_reboot_len: assert property (disable iff (srst_i || !wd_en_i)
    $rose(wd_reboot_o) |-> s_pulse ##0 wd_in_reboot_o)
    else $error("reboot pulse");
  a_warn_hold: assert property (
    wd_warn_irq_o && wd_en_i && !wd_warn_clr_i |=> wd_warn_irq_o)
    else $error("warning dropped");
  a_kick_gap: assert property (
    $rose(wd_warn_irq_o) |-> since_r + 32'h0000_0004 >= wd_warn_iv_i)
    else $error("early warning");
endmodule // iowd_sva
bind iowd_top iowd_sva iowd_sva_i (
  .clk_i          (clk_i),
  .srst_i         (srst_i),
  .usr_dir_i      (usr_dir_i),
  .usr_out_i      (usr_out_i),
  .usr_clr_i      (usr_clr_i),
  .usr_pin_o      (usr_pin_o),
  .usr_pin_oe_n_o (usr_pin_oe_n_o),
  .usr_flag_o     (usr_flag_o),
  .line_tx_o      (line_tx_o),
  .line_de_o      (line_de_o),
  .wd_en_i        (wd_en_i),
  .wd_kick_i      (wd_kick_i),
  .wd_warn_iv_i   (wd_warn_iv_i),
  .wd_warn_clr_i  (wd_warn_clr_i),
  .wd_warn_irq_o  (wd_warn_irq_o),
  .wd_reboot_o    (wd_reboot_o),
  .wd_in_reboot_o (wd_in_reboot_o)
);
`default_nettype wire

// ==== testbench/iowd_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iowd_bus_model (
  // clock
  input  wire logic clk_i,
  // shared pair
  input  wire logic de_i,
  input  wire logic tx_i,
  output var  logic rx_o
);
  logic drv = 1'b1;
  // two-wire pair, bias holds it high when free
  assign rx_o = de_i ? tx_i : drv;
  task automatic put(input logic [7:0] b, input int d);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    // never start a frame while the device drives the shared pair
    while (de_i) @(negedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      drv = f[i];
      repeat (d) @(negedge clk_i);
    end
  endtask
  task automatic get(input int d, output logic [7:0] b);
    @(negedge clk_i);
    while (!(de_i && !tx_i)) @(negedge clk_i);
    repeat (d / 2) @(negedge clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (d) @(negedge clk_i);
      b[i] = tx_i;
    end
    repeat (d) @(negedge clk_i);
  endtask
endmodule // iowd_bus_model
`default_nettype wire

// ==== testbench/iowd_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module iowd_top_tb;
  localparam int D = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] usr_dir_i, usr_out_i, usr_ie_i, usr_clr_i, usr_pin_i, baud_div_i;
  logic [15:0] usr_pin_o, usr_pin_oe_n_o, usr_in_o, usr_flag_o;
  logic [7:0]  tx_data_i, rx_data_o, got;
  logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i, rx_err_o, usr_irq_o;
  logic        line_rx_i, line_tx_o, line_de_o, wd_en_i, wd_kick_i, wd_host_up_i;
  logic        wd_warn_clr_i, wd_warn_irq_o, wd_reboot_o, wd_in_reboot_o;
  logic [31:0] wd_warn_iv_i, wd_tout_iv_i, wd_rbt_iv_i;
  int fails = 0, comparisons = 0, nrb = 0, ovl = 0;
  iowd_top iowd_top_i (
    .clk_i          (clk_i),
    .srst_i         (srst_i),
    .usr_dir_i      (usr_dir_i),
    .usr_out_i      (usr_out_i),
    .usr_ie_i       (usr_ie_i),
    .usr_clr_i      (usr_clr_i),
    .usr_pin_i      (usr_pin_i),
    .usr_pin_o      (usr_pin_o),
    .usr_pin_oe_n_o (usr_pin_oe_n_o),
    .usr_in_o       (usr_in_o),
    .usr_flag_o     (usr_flag_o),
    .usr_irq_o      (usr_irq_o),
    .baud_div_i     (baud_div_i),
    .tx_data_i      (tx_data_i),
    .tx_valid_i     (tx_valid_i),
    .tx_ready_o     (tx_ready_o),
    .rx_data_o      (rx_data_o),
    .rx_valid_o     (rx_valid_o),
    .rx_ready_i     (rx_ready_i),
    .rx_err_o       (rx_err_o),
    .line_rx_i      (line_rx_i),
    .line_tx_o      (line_tx_o),
    .line_de_o      (line_de_o),
    .wd_en_i        (wd_en_i),
    .wd_kick_i      (wd_kick_i),
    .wd_host_up_i   (wd_host_up_i),
    .wd_warn_iv_i   (wd_warn_iv_i),
    .wd_tout_iv_i   (wd_tout_iv_i),
    .wd_rbt_iv_i    (wd_rbt_iv_i),
    .wd_warn_clr_i  (wd_warn_clr_i),
    .wd_warn_irq_o  (wd_warn_irq_o),
    .wd_reboot_o    (wd_reboot_o),
    .wd_in_reboot_o (wd_in_reboot_o)
  );
  iowd_bus_model iowd_bus_model_i (.clk_i(clk_i), .de_i(line_de_o), .tx_i(line_tx_o),
    .rx_o(line_rx_i));
  always #12.5 clk_i = ~clk_i;
  always @(posedge wd_reboot_o) nrb++;
  always @(posedge clk_i) if (line_de_o && !iowd_bus_model_i.drv) ovl++;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      fails++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic push(input logic [7:0] d);
    tx_data_i = d;
    tx_valid_i = 1'b1;
    while (!tx_ready_o) cyc(1);
    cyc(1);
  endtask
  task automatic kick;
    wd_kick_i = 1'b1;
    cyc(1);
    wd_kick_i = 1'b0;
  endtask
  task automatic t_user;
    usr_dir_i = 16'h00ff;
    usr_out_i = 16'h00a5;
    usr_ie_i = 16'hff00;
    cyc(3);
    chk(usr_pin_oe_n_o, 16'hff00);
    chk(usr_pin_o & 16'h00ff, 16'h00a5);
    usr_pin_i = 16'h0100;
    cyc(5);
    chk(usr_flag_o, 16'h0100);
    chk(usr_irq_o, 1'b1);
    chk(usr_in_o, 16'h0100);
    usr_clr_i = 16'h0100;
    cyc(1);
    usr_clr_i = 16'h0000;
    cyc(2);
    chk(usr_irq_o, 1'b0);
  endtask
  task automatic t_ser;
    logic [7:0] q [4] = '{8'h5a, 8'h3c, 8'h81, 8'h0f};
    fork
      begin
        push(q[0]);
        push(q[1]);
        push(q[2]);
        chk(tx_ready_o, 1'b0);
        push(q[3]);
        tx_valid_i = 1'b0;
      end
      for (int i = 0; i < 4; i++)
      begin
        iowd_bus_model_i.get(D, got);
        chk(got, q[i]);
      end
    join
    iowd_bus_model_i.put(8'hc3, D);
    iowd_bus_model_i.put(8'h96, D);
    cyc(8);
    chk(rx_data_o, 8'hc3);
    chk(rx_err_o, 1'b0);
    rx_ready_i = 1'b1;
    cyc(1);
    rx_ready_i = 1'b0;
    chk(rx_valid_o, 1'b0);
    fork
      iowd_bus_model_i.put(8'he1, D);
      begin
        cyc(6);
        push(8'h77);
        tx_valid_i = 1'b0;
      end
      iowd_bus_model_i.get(D, got);
    join
    chk(got, 8'h77);
    chk(rx_data_o, 8'he1);
    chk(ovl, 0);
  endtask
  task automatic t_wd;
    wd_en_i = 1'b1;
    kick();
    repeat (5)
    begin
      cyc(12);
      kick();
    end
    chk(wd_warn_irq_o, 1'b0);
    cyc(30);
    chk(wd_warn_irq_o, 1'b1);
    chk(nrb, 0);
    wd_warn_clr_i = 1'b1;
    cyc(1);
    wd_warn_clr_i = 1'b0;
    cyc(17);
    chk(nrb, 1);
    chk(wd_in_reboot_o, 1'b1);
    cyc(80);
    chk(nrb, 2);
    wd_host_up_i = 1'b1;
    cyc(2);
    chk(wd_in_reboot_o, 1'b0);
    wd_en_i = 1'b0;
    cyc(200);
    chk({wd_warn_irq_o, wd_in_reboot_o}, 2'b00);
    chk(nrb, 2);
  endtask
  initial
  begin
    {usr_dir_i, usr_out_i, usr_ie_i, usr_clr_i, usr_pin_i} = '0;
    {tx_data_i, tx_valid_i, rx_ready_i, wd_en_i, wd_kick_i, wd_host_up_i} = '0;
    wd_warn_clr_i = 1'b0;
    baud_div_i = 16'h0004;
    wd_warn_iv_i = 32'h0000_0014;
    wd_tout_iv_i = 32'h0000_0028;
    wd_rbt_iv_i = 32'h0000_003c;
    cyc(4);
    srst_i = 1'b0;
    t_user();
    t_ser();
    t_wd();
    report_and_stop();
  end
  initial
  begin
    #(25 * 5000);
    fails++;
    report_and_stop();
  end
endmodule // iowd_top_tb
`default_nettype wire
